// ==== rtl/ifsts_top.sv ====
// live input fault status registers for the diagnosed input channels
//
// How it works
// - bit 7 reports open input
// - bit 6 reports input pair shorted together
// - bit 5 reports positive leg shorted to ground
// - bit 4 reports negative leg shorted to ground
// - bit 3 reports positive leg shorted to bias
// - bit 2 reports negative leg shorted to bias
// - bit 1 reports positive leg shorted to battery
// - bit 0 reports negative leg shorted to battery
// - all bits read-only, reset to zero
// - channel three at 0x30, four at 0x31
// - channel five at 0x32, six at 0x33
// - channels five and six only on six-channel part
// - registers show live detector state, not history
// - channel one at 0x2E, same layout
`timescale 1ns/100ps
module ifsts_top
    import ifsts_pkg::*;
#(
    parameter bit SIX_CHANNEL = 1'b1  // six-channel variant when set
)(
    input  wire logic         core_clk,    // 250 MHz control clock
    input  wire logic         rst_b,       // async reset, active low
    input  wire ifsts_req_t   reg_req,     // register access request
    output logic [7:0]        reg_rdata,   // read data, registered
    output logic              reg_rvalid,  // read data valid, pulse
    output logic              reg_hit,     // last read hit a register
    input  wire ifsts_fault_t fault_ch1,   // channel 1 detectors
    input  wire ifsts_fault_t fault_ch3,   // channel 3 detectors
    input  wire ifsts_fault_t fault_ch4,   // channel 4 detectors
    input  wire ifsts_fault_t fault_ch5,   // channel 5 detectors
    input  wire ifsts_fault_t fault_ch6    // channel 6 detectors
);

    localparam logic [7:0] ADDR_TBL [IFSTS_NUM_CH] = '{
        IFSTS_ADDR_CH1, IFSTS_ADDR_CH3, IFSTS_ADDR_CH4,
        IFSTS_ADDR_CH5, IFSTS_ADDR_CH6
    };

    logic rst_meta_b;
    logic rst_sync_b;

    // reset asserts at once and releases two edges later
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_b <= 1'b1;
            rst_sync_b <= rst_meta_b;
        end
    end

    ifsts_fault_t raw    [IFSTS_NUM_CH];
    ifsts_fault_t status [IFSTS_NUM_CH];
    logic         present[IFSTS_NUM_CH];

    assign raw[0] = fault_ch1;
    assign raw[1] = fault_ch3;
    assign raw[2] = fault_ch4;
    assign raw[3] = fault_ch5;
    assign raw[4] = fault_ch6;

    for (genvar i = 0; i < IFSTS_NUM_CH; i++) begin : g_chan
        // the four-channel part has no channel five or six
        assign present[i] = (i < IFSTS_FIRST_OPT) || SIX_CHANNEL;
        ifsts_chan_status u_chan (
            .core_clk   (core_clk),
            .rst_sync_b (rst_sync_b),
            .present    (present[i]),
            .fault_raw  (raw[i]),
            .status     (status[i])
        );
    end

    logic       sel_hit;
    logic [7:0] sel_data;

    // address decode over the status page
    always_comb begin
        sel_hit  = 1'b0;
        sel_data = IFSTS_RESET_VAL;
        if (reg_req.page == IFSTS_PAGE) begin
            for (int i = 0; i < IFSTS_NUM_CH; i++) begin
                if (present[i] && reg_req.addr == ADDR_TBL[i]) begin
                    sel_hit  = 1'b1;
                    sel_data = status[i];
                end
            end
        end
    end

    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic       rvalid_reg;
    logic       rvalid_next;
    logic       hit_reg;
    logic       hit_next;

    // a write has no path into the status, so it cannot disturb it
    always_comb begin
        rvalid_next = reg_req.rd;
        hit_next    = reg_req.rd ? sel_hit : hit_reg;
        rdata_next  = rdata_reg;
        if (reg_req.rd) begin
            // unmapped or absent addresses read zero
            rdata_next = sel_hit ? sel_data : IFSTS_RESET_VAL;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            rdata_reg  <= IFSTS_RESET_VAL;
            rvalid_reg <= 1'b0;
            hit_reg    <= 1'b0;
        end else begin
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
            hit_reg    <= hit_next;
        end
    end

    assign reg_rdata  = rdata_reg;
    assign reg_rvalid = rvalid_reg;
    assign reg_hit    = hit_reg;

    // checks

    logic rd_ch3;
    logic rd_ch4;
    logic rd_ch5;
    logic rd_ch6;
    logic rd_ch1;

    assign rd_ch3 = reg_req.rd && reg_req.page == IFSTS_PAGE
                    && reg_req.addr == IFSTS_ADDR_CH3;
    assign rd_ch4 = reg_req.rd && reg_req.page == IFSTS_PAGE
                    && reg_req.addr == IFSTS_ADDR_CH4;
    assign rd_ch5 = reg_req.rd && reg_req.page == IFSTS_PAGE
                    && reg_req.addr == IFSTS_ADDR_CH5;
    assign rd_ch6 = reg_req.rd && reg_req.page == IFSTS_PAGE
                    && reg_req.addr == IFSTS_ADDR_CH6;
    assign rd_ch1 = reg_req.rd && reg_req.page == IFSTS_PAGE
                    && reg_req.addr == IFSTS_ADDR_CH1;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_sync_b);

    property p_open;
        rd_ch3 |=> reg_rdata[IFSTS_BIT_OPEN] == $past(status[1].open_input);
    endproperty
    a_open: assert property (p_open)
        else $error("open input bit wrong");

    property p_pair;
        rd_ch4 |=> reg_rdata[IFSTS_BIT_PAIR] == $past(status[2].pair_short);
    endproperty
    a_pair: assert property (p_pair)
        else $error("pair short bit wrong");

    property p_pos_gnd;
        rd_ch3 ##1 $past(raw[1].pos_to_gnd, 3) |-> reg_rdata[IFSTS_BIT_POS_GND];
    endproperty
    a_pos_gnd: assert property (p_pos_gnd)
        else $error("positive ground bit not set");

    property p_neg_gnd;
        rd_ch4 |=> reg_rdata[IFSTS_BIT_NEG_GND]
                   == $past(raw[2].neg_to_gnd, 3);
    endproperty
    a_neg_gnd: assert property (p_neg_gnd)
        else $error("negative ground bit wrong");

    property p_pos_bias;
        rd_ch1 |=> reg_rdata[IFSTS_BIT_POS_BIAS]
                   == $past(status[0].pos_to_mic_bias);
    endproperty
    a_pos_bias: assert property (p_pos_bias)
        else $error("positive bias bit wrong");

    property p_neg_bias;
        rd_ch3 |=> reg_rdata[IFSTS_BIT_NEG_BIAS]
                   == $past(status[1].neg_to_mic_bias);
    endproperty
    a_neg_bias: assert property (p_neg_bias)
        else $error("negative bias bit wrong");

    property p_pos_bat;
        rd_ch6 && SIX_CHANNEL |=> reg_rdata[IFSTS_BIT_POS_BAT]
                   == $past(status[4].pos_to_battery);
    endproperty
    a_pos_bat: assert property (p_pos_bat)
        else $error("positive battery bit wrong");

    property p_neg_bat;
        rd_ch5 && SIX_CHANNEL |=> reg_rdata[IFSTS_BIT_NEG_BAT]
                   == $past(status[3].neg_to_battery);
    endproperty
    a_neg_bat: assert property (p_neg_bat)
        else $error("negative battery bit wrong");

    property p_absent;
        (rd_ch5 || rd_ch6) && !SIX_CHANNEL |=> reg_rdata == 8'h00 && !reg_hit;
    endproperty
    a_absent: assert property (p_absent)
        else $error("absent channel answered");

    sequence s_steady_fault;
        $stable(raw[2]) [*3];
    endsequence

    property p_live;
        s_steady_fault |-> status[2] == raw[2];
    endproperty
    a_live: assert property (p_live)
        else $error("status not following detector");

    property p_hit;
        rd_ch3 || rd_ch4 |=> reg_rvalid && reg_hit;
    endproperty
    a_hit: assert property (p_hit)
        else $error("status read not answered");

    property p_write_ignored;
        reg_req.wr && !reg_req.rd |=> $stable(reg_rdata);
    endproperty
    a_write_ignored: assert property (p_write_ignored)
        else $error("write changed read data");

    property p_reset_zero;
        @(posedge core_clk) $rose(rst_sync_b) |-> reg_rdata == 8'h00;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("read data not zero at reset release");

endmodule

// ==== inc/ifsts_pkg.sv ====
// constants and types for the input fault live status registers
package ifsts_pkg;

    // per-channel fault bit positions
    localparam int IFSTS_BIT_OPEN     = 7;
    localparam int IFSTS_BIT_PAIR     = 6;
    localparam int IFSTS_BIT_POS_GND  = 5;
    localparam int IFSTS_BIT_NEG_GND  = 4;
    localparam int IFSTS_BIT_POS_BIAS = 3;
    localparam int IFSTS_BIT_NEG_BIAS = 2;
    localparam int IFSTS_BIT_POS_BAT  = 1;
    localparam int IFSTS_BIT_NEG_BAT  = 0;

    // register page and addresses
    localparam logic [7:0] IFSTS_PAGE      = 8'h01;
    localparam logic [7:0] IFSTS_ADDR_CH1  = 8'h2E;
    localparam logic [7:0] IFSTS_ADDR_CH3  = 8'h30;
    localparam logic [7:0] IFSTS_ADDR_CH4  = 8'h31;
    localparam logic [7:0] IFSTS_ADDR_CH5  = 8'h32;
    localparam logic [7:0] IFSTS_ADDR_CH6  = 8'h33;

    localparam logic [7:0] IFSTS_RESET_VAL = 8'h00;
    localparam int         IFSTS_SYNC_LAT  = 2;

    // channel slots: 0=ch1, 1=ch3, 2=ch4, 3=ch5, 4=ch6
    localparam int IFSTS_NUM_CH    = 5;
    localparam int IFSTS_FIRST_OPT = 3;

    // field order matches the register bit order, msb first
    typedef struct packed {
        logic open_input;
        logic pair_short;
        logic pos_to_gnd;
        logic neg_to_gnd;
        logic pos_to_mic_bias;
        logic neg_to_mic_bias;
        logic pos_to_battery;
        logic neg_to_battery;
    } ifsts_fault_t;

    typedef struct packed {
        logic [7:0] page;
        logic [7:0] addr;
        logic       rd;
        logic       wr;
        logic [7:0] wdata;
    } ifsts_req_t;

endpackage

// ==== rtl/ifsts_chan_status.sv ====
// one channel's live fault status: detector sync and status register
`timescale 1ns/100ps
module ifsts_chan_status
    import ifsts_pkg::*;
(
    input  wire logic         core_clk,  // control clock
    input  wire logic         rst_sync_b, // synced reset, active low
    input  wire logic         present,   // channel exists on this variant
    input  wire ifsts_fault_t fault_raw, // analog detector outputs
    output ifsts_fault_t      status     // live status, registered
);

    ifsts_fault_t meta_reg;
    ifsts_fault_t meta_next;
    ifsts_fault_t status_reg;
    ifsts_fault_t status_next;

    // second stage is the live value itself, so no history is kept
    always_comb begin
        meta_next   = fault_raw;
        status_next = meta_reg;
    end

    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            meta_reg   <= ifsts_fault_t'(IFSTS_RESET_VAL);
            status_reg <= ifsts_fault_t'(IFSTS_RESET_VAL);
        end else begin
            meta_reg   <= meta_next;
            status_reg <= status_next;
        end
    end

    // gated after the second flop so only that flop reads the first stage
    assign status = present ? status_reg
                            : ifsts_fault_t'(IFSTS_RESET_VAL);

endmodule

// ==== verification/tb_input_fault_live_status.sv ====
// self-checking bench for the input fault live status registers
`timescale 1ns/100ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin \
    n_errors++; $display("MISMATCH %0t: got %h exp %h", $time, got, exp); \
    end end
module tb_input_fault_live_status;
    import ifsts_pkg::*;
    logic         core_clk;
    logic         rst_b;
    ifsts_req_t   reg_req;
    logic [7:0]   reg_rdata;
    logic         reg_rvalid;
    logic         reg_hit;
    logic [7:0]   rdata4;
    logic         rvalid4;
    logic         hit4;
    ifsts_fault_t fault_ch1, fault_ch3, fault_ch4, fault_ch5, fault_ch6;
    logic [17:0]  exp_q[$];
    logic [17:0]  e;
    logic         last_rd = 1'b0;
    int           n_errors;
    int           compares;

    ifsts_top #(.SIX_CHANNEL(1'b1)) i_ifsts_top (
        .core_clk(core_clk), .rst_b(rst_b), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_hit(reg_hit),
        .fault_ch1(fault_ch1), .fault_ch3(fault_ch3), .fault_ch4(fault_ch4),
        .fault_ch5(fault_ch5), .fault_ch6(fault_ch6));

    // four-channel variant sees the same traffic
    ifsts_top #(.SIX_CHANNEL(1'b0)) i_ifsts_top_four (
        .core_clk(core_clk), .rst_b(rst_b), .reg_req(reg_req),
        .reg_rdata(rdata4), .reg_rvalid(rvalid4), .reg_hit(hit4),
        .fault_ch1(fault_ch1), .fault_ch3(fault_ch3), .fault_ch4(fault_ch4),
        .fault_ch5(fault_ch5), .fault_ch6(fault_ch6));

    always #2 core_clk = ~core_clk;

    // {hit, data} a read should return, for one variant
    function automatic logic [8:0] model(logic [7:0] pg, logic [7:0] ad,
                                         bit six);
        if (pg !== 8'h01) return 9'h000;
        case (ad)
            8'h2E: return {1'b1, fault_ch1};
            8'h30: return {1'b1, fault_ch3};
            8'h31: return {1'b1, fault_ch4};
            8'h32: return six ? {1'b1, fault_ch5} : 9'h000;
            8'h33: return six ? {1'b1, fault_ch6} : 9'h000;
            default: return 9'h000;
        endcase
    endfunction

    task automatic issue(logic [7:0] pg, logic [7:0] ad, logic rd,
                         logic wr, logic [7:0] wd);
        @(posedge core_clk);
        reg_req <= '{page: pg, addr: ad, rd: rd, wr: wr, wdata: wd};
        if (rd) exp_q.push_back({model(pg, ad, 1), model(pg, ad, 0)});
    endtask

    // faults stay put across a sweep, so the model sees settled status
    task automatic sweep();
        for (int a = 8'h2D; a <= 8'h34; a++) begin
            issue(8'h01, 8'(a), 1'b0, 1'b1, 8'($urandom));
            issue(8'h01, 8'(a), 1'b1, 1'b0, 8'h00);
        end
        issue(8'h00, 8'h30, 1'b1, 1'b0, 8'h00);
        issue(8'h01, 8'h31, 1'b1, 1'b1, 8'hFF);
        issue(8'h01, 8'($urandom_range(8'h2C, 8'h36)), 1'b1, 1'b0, 8'h00);
        @(posedge core_clk);
        reg_req.rd <= 1'b0;
        reg_req.wr <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask

    task automatic set_faults(logic [39:0] v);
        @(posedge core_clk);
        {fault_ch1, fault_ch3, fault_ch4, fault_ch5, fault_ch6} <= v;
        repeat (4) @(posedge core_clk); // covers the two-flop sync
    endtask

    // every answer is checked one edge after its request is driven
    always @(posedge core_clk) begin
        #1;
        `CHK(rvalid4, reg_rvalid)
        `CHK(reg_rvalid, last_rd)
        if (reg_rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                `CHK(reg_rvalid, 1'b0)
            end else begin
                e = exp_q.pop_front();
                `CHK(reg_rdata, e[16:9])
                `CHK(reg_hit, e[17])
                `CHK(rdata4, e[7:0])
                `CHK(hit4, e[8])
            end
        end
        // the read the design takes at the next edge must answer then
        last_rd = reg_req.rd;
    end

    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        #20000;
        n_errors++;
        $display("MISMATCH %0t: run did not finish", $time);
        summarize();
    end

    initial begin
        core_clk = 1'b0;
        rst_b = 1'b0;
        reg_req = '0;
        {fault_ch1, fault_ch3, fault_ch4, fault_ch5, fault_ch6} = '0;
        n_errors = 0;
        compares = 0;
        void'($urandom(14));
        repeat (6) @(posedge core_clk);
        `CHK(reg_rdata, 8'h00)
        `CHK(reg_hit, 1'b0)
        `CHK(reg_rvalid, 1'b0)
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge core_clk);
        sweep();
        // one bit at a time per channel; the previous bit must drop
        for (int b = 0; b < 8; b++) begin
            set_faults({8'h01 << b, 8'h80 >> b, 8'h01 << ((b + 1) % 8),
                        8'h01 << ((b + 3) % 8), 8'h01 << ((b + 5) % 8)});
            sweep();
        end
        for (int r = 0; r < 25; r++) begin
            set_faults({$urandom, 8'($urandom)});
            sweep();
        end
        set_faults('0);
        sweep();
        `CHK(exp_q.size(), 0)
        summarize();
    end
endmodule
